// ==== verilog/pdes_select.sv ====
// Purpose: Pin-function select for port D lines 0-3 and port E lines 0-2, 7.
// Assumes: AXI4-Lite slave, rst synchronous active high, 10 MHz mclk.
// Notes: Pad drive and peripheral inputs are registered, one cycle late.
// Function
// R1: Port D line 3 field 7:6 picks GPIO with timer-2 clock, timer-7 out, analog 11 or LCD seg 33.
// R2: Port D line 2 field 5:4 picks GPIO, timer-2 out, UART1 transmit or analog 10.
// R3: Port D line 1 field 3:2 picks GPIO with std timer-1 clock, UART1 shared, analog 9 or seg 34.
// R4: Port D line 0 field 1:0 picks GPIO with interrupt 2, std timer-1 out, analog 8 or seg 35.
// R5: Bits 7:6 of the high port D selector are not stored, read zero and ignore writes.
// R6: Port E line 2 field 5:4 picks GPIO with timer-1 clock, UART2 transmit, SPI data in or seg 5.
// R7: Port E line 1 field picks GPIO, std timer-0 out, SPI data out or LCD seg 6.
// R8: Port E line 0 field picks GPIO with std timer-0 clock, UART2 shared, SPI select or seg 7.
// R9: Port E line 7 field 7:6 gives GPIO for codes 00 and 01 and LCD seg 43 for 11.
// R10: Software never writes code 10 into the port E line 7 field.
// R11: A peripheral or LCD choice drives pin value and direction, otherwise GPIO does.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pdes_select
  import pdes_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_d_gpio_out,
  input wire logic [7:0] port_d_gpio_dir,
  input wire logic [7:0] port_e_gpio_out,
  input wire logic [7:0] port_e_gpio_dir,
  input wire logic [7:0] port_d_pin_in,
  input wire logic [7:0] port_e_pin_in,
  output logic [7:0] port_d_pin_out,
  output logic [7:0] port_d_pin_oe,
  output logic [7:0] port_e_pin_out,
  output logic [7:0] port_e_pin_oe,
  input wire logic periodic_timer7_output,
  input wire logic periodic_timer2_output,
  input wire logic standard_timer1_output,
  input wire logic standard_timer0_output,
  input wire logic uart1_transmit,
  input wire logic uart1_shared_out,
  input wire logic uart1_shared_oe,
  input wire logic uart2_transmit,
  input wire logic uart2_shared_out,
  input wire logic uart2_shared_oe,
  input wire logic spi_serial_out,
  input wire logic spi_chip_select_out,
  input wire logic spi_chip_select_oe,
  input wire logic lcd_segment_33,
  input wire logic lcd_segment_34,
  input wire logic lcd_segment_35,
  input wire logic lcd_segment_5,
  input wire logic lcd_segment_6,
  input wire logic lcd_segment_7,
  input wire logic lcd_segment_43,
  output logic periodic_timer2_clock_in,
  output logic periodic_timer1_clock_in,
  output logic standard_timer1_clock_in,
  output logic standard_timer0_clock_in,
  output logic external_interrupt_2,
  output logic uart1_shared_in,
  output logic uart2_shared_in,
  output logic spi_serial_in,
  output logic spi_chip_select_in,
  output logic [3:0] analog_enable
);

  // Refuse an address bus too narrow for the map
  if (ADDR_W < 4)
  begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic [7:0] port_d_select_low, port_d_select_high;
  logic [7:0] port_e_select_low, port_e_select_high;
  logic [7:0] next_pdl, next_pdh, next_pel, next_peh;
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane, next_w_lane;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic do_write;
  logic [7:0] wsel;

  // Bus handshake outputs
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign do_write = aw_held && w_held && !bvalid;
  assign wsel = 8'(aw_addr);

  // Write channel capture and register update
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_pdl = port_d_select_low;
    next_pdh = port_d_select_high;
    next_pel = port_e_select_low;
    next_peh = port_e_select_high;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = PDES_RESP_OKAY;
      case ({wsel[7:2], 2'b00})
        PDES_PDL_OFF: if (w_lane) next_pdl = w_byte;
        PDES_PDH_OFF: if (w_lane) next_pdh = w_byte & PDES_PDH_MASK; // R5
        PDES_PEL_OFF: if (w_lane) next_pel = w_byte;
        PDES_PEH_OFF: if (w_lane) next_peh = w_byte;
        default: next_bresp = PDES_RESP_SLVERR;
      endcase
      if (ADDR_W > 8 && (aw_addr >> 8) != '0)
        next_bresp = PDES_RESP_SLVERR;
    end
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= PDES_SEL_RST;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= PDES_RESP_OKAY;
      port_d_select_low <= PDES_SEL_RST;
      port_d_select_high <= PDES_SEL_RST;
      port_e_select_low <= PDES_SEL_RST;
      port_e_select_high <= PDES_SEL_RST;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      port_d_select_low <= next_pdl;
      port_d_select_high <= next_pdh;
      port_e_select_low <= next_pel;
      port_e_select_high <= next_peh;
    end
  end

  reserved_bits_a: assert property (port_d_select_high[7:6] == 2'b00) // R5
    else $error("reserved select bits became set");

  // Read channel, answer one cycle after address
  always_comb
  begin
    logic [7:0] rsel;
    rsel = 8'(s_axi_araddr);
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = PDES_RESP_OKAY;
      case ({rsel[7:2], 2'b00})
        PDES_PDL_OFF: next_rdata = {PDES_RD_PAD, port_d_select_low};
        PDES_PDH_OFF: next_rdata = {PDES_RD_PAD, port_d_select_high & PDES_PDH_MASK}; // R5
        PDES_PEL_OFF: next_rdata = {PDES_RD_PAD, port_e_select_low};
        PDES_PEH_OFF: next_rdata = {PDES_RD_PAD, port_e_select_high};
        default:
        begin
          next_rdata = '0;
          next_rresp = PDES_RESP_SLVERR;
        end
      endcase
      if (ADDR_W > 8 && (s_axi_araddr >> 8) != '0)
        next_rresp = PDES_RESP_SLVERR;
    end
    else if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= PDES_RESP_OKAY;
    end
    else
    begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Field extraction
  logic [1:0] sd3, sd2, sd1, sd0, se2, se1, se0, se7;
  assign sd3 = port_d_select_low[PDES_F3_LSB +: 2];
  assign sd2 = port_d_select_low[PDES_F2_LSB +: 2];
  assign sd1 = port_d_select_low[PDES_F1_LSB +: 2];
  assign sd0 = port_d_select_low[PDES_F0_LSB +: 2];
  assign se2 = port_e_select_low[PDES_F2_LSB +: 2];
  assign se1 = port_e_select_low[PDES_F1_LSB +: 2];
  assign se0 = port_e_select_low[PDES_F0_LSB +: 2];
  assign se7 = port_e_select_high[PDES_F3_LSB +: 2];

  logic [7:0] next_d_out, next_d_oe, next_e_out, next_e_oe;
  logic [3:0] next_an;
  logic next_pt2ck, next_pt1ck, next_st1ck, next_st0ck, next_ext_irq2;
  logic next_u1in, next_u2in, next_sdi, next_csin;

  // Pad drive and peripheral input routing
  always_comb
  begin
    next_d_out = port_d_gpio_out; // R11
    next_d_oe = port_d_gpio_dir; // R11
    next_e_out = port_e_gpio_out; // R11
    next_e_oe = port_e_gpio_dir; // R11
    next_an = 4'h0;
    next_pt2ck = 1'b0;
    next_pt1ck = 1'b0;
    next_st1ck = 1'b0;
    next_st0ck = 1'b0;
    next_ext_irq2 = 1'b0;
    next_u1in = 1'b0;
    next_u2in = 1'b0;
    next_sdi = 1'b0;
    next_csin = PDES_CS_IDLE;
    case (sd3) // R1
      PDES_C00: next_pt2ck = port_d_pin_in[3];
      PDES_C01: {next_d_out[3], next_d_oe[3]} = {periodic_timer7_output, 1'b1};
      PDES_C10: {next_d_out[3], next_d_oe[3], next_an[3]} = 3'b001;
      default: {next_d_out[3], next_d_oe[3]} = {lcd_segment_33, 1'b1};
    endcase
    case (sd2) // R2
      PDES_C00: ;
      PDES_C01: {next_d_out[2], next_d_oe[2]} = {periodic_timer2_output, 1'b1};
      PDES_C10: {next_d_out[2], next_d_oe[2]} = {uart1_transmit, 1'b1};
      default: {next_d_out[2], next_d_oe[2], next_an[2]} = 3'b001;
    endcase
    case (sd1) // R3
      PDES_C00: next_st1ck = port_d_pin_in[1];
      PDES_C01:
      begin
        {next_d_out[1], next_d_oe[1]} = {uart1_shared_out, uart1_shared_oe};
        next_u1in = port_d_pin_in[1];
      end
      PDES_C10: {next_d_out[1], next_d_oe[1], next_an[1]} = 3'b001;
      default: {next_d_out[1], next_d_oe[1]} = {lcd_segment_34, 1'b1};
    endcase
    case (sd0) // R4
      PDES_C00: next_ext_irq2 = port_d_pin_in[0];
      PDES_C01: {next_d_out[0], next_d_oe[0]} = {standard_timer1_output, 1'b1};
      PDES_C10: {next_d_out[0], next_d_oe[0], next_an[0]} = 3'b001;
      default: {next_d_out[0], next_d_oe[0]} = {lcd_segment_35, 1'b1};
    endcase
    case (se2) // R6
      PDES_C00: next_pt1ck = port_e_pin_in[2];
      PDES_C01: {next_e_out[2], next_e_oe[2]} = {uart2_transmit, 1'b1};
      PDES_C10:
      begin
        {next_e_out[2], next_e_oe[2]} = 2'b00;
        next_sdi = port_e_pin_in[2];
      end
      default: {next_e_out[2], next_e_oe[2]} = {lcd_segment_5, 1'b1};
    endcase
    case (se1) // R7
      PDES_C00: ;
      PDES_C01: {next_e_out[1], next_e_oe[1]} = {standard_timer0_output, 1'b1};
      PDES_C10: {next_e_out[1], next_e_oe[1]} = {spi_serial_out, 1'b1};
      default: {next_e_out[1], next_e_oe[1]} = {lcd_segment_6, 1'b1};
    endcase
    case (se0) // R8
      PDES_C00: next_st0ck = port_e_pin_in[0];
      PDES_C01:
      begin
        {next_e_out[0], next_e_oe[0]} = {uart2_shared_out, uart2_shared_oe};
        next_u2in = port_e_pin_in[0];
      end
      PDES_C10:
      begin
        {next_e_out[0], next_e_oe[0]} = {spi_chip_select_out, spi_chip_select_oe};
        next_csin = port_e_pin_in[0];
      end
      default: {next_e_out[0], next_e_oe[0]} = {lcd_segment_7, 1'b1};
    endcase
    // Code 10 is never written; it falls back to GPIO here
    if (se7 == PDES_C11) // R9 R10
      {next_e_out[7], next_e_oe[7]} = {lcd_segment_43, 1'b1};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      port_d_pin_out <= 8'h00;
      port_d_pin_oe <= 8'h00;
      port_e_pin_out <= 8'h00;
      port_e_pin_oe <= 8'h00;
      analog_enable <= 4'h0;
      periodic_timer2_clock_in <= 1'b0;
      periodic_timer1_clock_in <= 1'b0;
      standard_timer1_clock_in <= 1'b0;
      standard_timer0_clock_in <= 1'b0;
      external_interrupt_2 <= 1'b0;
      uart1_shared_in <= 1'b0;
      uart2_shared_in <= 1'b0;
      spi_serial_in <= 1'b0;
      spi_chip_select_in <= PDES_CS_IDLE;
    end
    else
    begin
      port_d_pin_out <= next_d_out;
      port_d_pin_oe <= next_d_oe;
      port_e_pin_out <= next_e_out;
      port_e_pin_oe <= next_e_oe;
      analog_enable <= next_an;
      periodic_timer2_clock_in <= next_pt2ck;
      periodic_timer1_clock_in <= next_pt1ck;
      standard_timer1_clock_in <= next_st1ck;
      standard_timer0_clock_in <= next_st0ck;
      external_interrupt_2 <= next_ext_irq2;
      uart1_shared_in <= next_u1in;
      uart2_shared_in <= next_u2in;
      spi_serial_in <= next_sdi;
      spi_chip_select_in <= next_csin;
    end
  end

  // Routing checks, one cycle after the select is seen, not from a reset cycle
  d3_lcd_drive_a: assert property ((sd3 == PDES_C11) |=> // R1
    port_d_pin_oe[3] && port_d_pin_out[3] == $past(lcd_segment_33))
    else $error("port D line 3 not driving its LCD segment");
  d2_uart_tx_a: assert property ((sd2 == PDES_C10) |=> // R2
    port_d_pin_oe[2] && port_d_pin_out[2] == $past(uart1_transmit))
    else $error("port D line 2 not driving UART1 transmit");
  d1_analog_a: assert property ((sd1 == PDES_C10) |=> // R3
    !port_d_pin_oe[1] && analog_enable[1])
    else $error("port D line 1 not released to analog");
  d0_interrupt_a: assert property (!rst && (sd0 == PDES_C00) |=> // R4
    external_interrupt_2 == $past(port_d_pin_in[0]))
    else $error("interrupt 2 not following port D line 0");
  e2_spi_in_a: assert property ((se2 == PDES_C10) |=> // R6
    !port_e_pin_oe[2] && spi_serial_in == $past(port_e_pin_in[2]))
    else $error("SPI data in not taken from port E line 2");
  e1_timer_out_a: assert property ((se1 == PDES_C01) |=> // R7
    port_e_pin_oe[1] && port_e_pin_out[1] == $past(standard_timer0_output))
    else $error("port E line 1 not driving timer 0");
  e0_uart2_a: assert property ((se0 == PDES_C01) |=> // R8
    port_e_pin_oe[0] == $past(uart2_shared_oe))
    else $error("port E line 0 direction not from UART2");
  e7_gpio_a: assert property (!rst && (se7[1] == 1'b0) |=> // R9
    port_e_pin_out[7] == $past(port_e_gpio_out[7]))
    else $error("port E line 7 not following GPIO");
  d3_gpio_a: assert property (!rst && (sd3 == PDES_C00) |=> // R11
    port_d_pin_out[3] == $past(port_d_gpio_out[3])
    && port_d_pin_oe[3] == $past(port_d_gpio_dir[3]))
    else $error("port D line 3 not under GPIO control");

endmodule
`default_nettype wire

// ==== verilog/pdes_pkg.sv ====
// Purpose: Constants for the port D/E pin-function selector.
// Assumes: 8-bit select registers on 32-bit AXI4-Lite words.
// Notes: Field codes are named by their bit pattern only.
`default_nettype none
package pdes_pkg;
  // Register byte offsets
  localparam logic [7:0] PDES_PDL_OFF = 8'h00;
  localparam logic [7:0] PDES_PDH_OFF = 8'h04;
  localparam logic [7:0] PDES_PEL_OFF = 8'h08;
  localparam logic [7:0] PDES_PEH_OFF = 8'h0C;
  localparam logic [7:0] PDES_SEL_RST = 8'h00;
  localparam logic [7:0] PDES_PDH_MASK = 8'h3F;
  // Field positions inside a select register
  localparam int PDES_F0_LSB = 0;
  localparam int PDES_F1_LSB = 2;
  localparam int PDES_F2_LSB = 4;
  localparam int PDES_F3_LSB = 6;
  // Field codes
  localparam logic [1:0] PDES_C00 = 2'h0;
  localparam logic [1:0] PDES_C01 = 2'h1;
  localparam logic [1:0] PDES_C10 = 2'h2;
  localparam logic [1:0] PDES_C11 = 2'h3;
  // Bus responses and idle levels
  localparam logic [1:0] PDES_RESP_OKAY = 2'h0;
  localparam logic [1:0] PDES_RESP_SLVERR = 2'h2;
  localparam logic PDES_CS_IDLE = 1'b1;
  localparam logic [23:0] PDES_RD_PAD = 24'h00_0000;
endpackage
`default_nettype wire

// ==== sim/tb_port_d_e_function_select.sv ====
// Purpose: Self-checking bench for the port D/E pin-function selector.
// Assumes: AXI4-Lite master tasks, one clock at 10 MHz, synchronous reset.
// Notes: Each mux case sets one field and drives high only its expected source and any enable bit, or GPIO for an input-only code.
`timescale 1ns/10ps
`default_nettype none
module tb_port_d_e_function_select;
  import pdes_pkg::*;
  logic mclk;
  logic rst;
  logic [7:0] s_axi_awaddr;
  logic [7:0] s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp;
  wire logic [1:0] s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  logic [7:0] gpo, gpd, pin;
  logic [19:0] pv;
  wire logic [7:0] d_out, d_oe, e_out, e_oe;
  wire logic [8:0] inx;
  wire logic [3:0] analog_enable;
  int failures;
  int compares;

  // Device under test, peripheral sources taken from one vector
  pdes_select #(.ADDR_W(8)) pdes_select_i (
    .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_d_gpio_out(gpo), .port_d_gpio_dir(gpd), .port_e_gpio_out(gpo),
    .port_e_gpio_dir(gpd), .port_d_pin_in(pin), .port_e_pin_in(pin),
    .port_d_pin_out(d_out), .port_d_pin_oe(d_oe), .port_e_pin_out(e_out),
    .port_e_pin_oe(e_oe), .periodic_timer7_output(pv[0]), .periodic_timer2_output(pv[1]),
    .standard_timer1_output(pv[2]), .standard_timer0_output(pv[3]),
    .uart1_transmit(pv[4]), .uart1_shared_out(pv[5]), .uart1_shared_oe(pv[6]),
    .uart2_transmit(pv[7]), .uart2_shared_out(pv[8]), .uart2_shared_oe(pv[9]),
    .spi_serial_out(pv[10]), .spi_chip_select_out(pv[11]), .spi_chip_select_oe(pv[12]),
    .lcd_segment_33(pv[13]), .lcd_segment_34(pv[14]), .lcd_segment_35(pv[15]),
    .lcd_segment_5(pv[16]), .lcd_segment_6(pv[17]), .lcd_segment_7(pv[18]),
    .lcd_segment_43(pv[19]), .periodic_timer2_clock_in(inx[0]),
    .periodic_timer1_clock_in(inx[1]), .standard_timer1_clock_in(inx[2]),
    .standard_timer0_clock_in(inx[3]), .external_interrupt_2(inx[4]),
    .uart1_shared_in(inx[5]), .uart2_shared_in(inx[6]), .spi_serial_in(inx[7]),
    .spi_chip_select_in(inx[8]), .analog_enable
  );

  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] x);
    begin
      compares++;
      if (g !== x)
      begin
        failures++;
        $display("BAD %s expected %h seen %h", nm, x, g);
      end
    end
  endtask

  // Verdict and end of run
  task automatic summarize;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // AXI4-Lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs);
    int n;
    begin
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge mclk);
        n++;
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 100);
      if (n == 100)
        failures++;
      chk("bresp", s_axi_bresp, rs);
      s_axi_bready <= 1'b0;
      @(posedge mclk);
    end
  endtask

  // AXI4-Lite read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs);
    int n;
    begin
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge mclk);
        n++;
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 100);
      if (n == 100)
        failures++;
      chk("rdata", s_axi_rdata, {24'h00_0000, d});
      chk("rresp", s_axi_rresp, rs);
      s_axi_rready <= 1'b0;
      @(posedge mclk);
    end
  endtask

  // One field code: so source bit, -1 GPIO, -2 input only; se enable bit
  task automatic mux(input bit e, input int ln, input logic [1:0] c, input int so,
    input int se, input logic [3:0] an, input logic [8:0] ix);
    logic [7:0] a;
    logic [7:0] v;
    logic [1:0] po;
    begin
      a = e ? ((ln == 7) ? PDES_PEH_OFF : PDES_PEL_OFF) : PDES_PDL_OFF;
      v = 8'h00;
      v[((ln == 7) ? 6 : 2 * ln)+:2] = c;
      gpo <= (so < 0) ? 8'hFF : 8'h00;
      gpd <= (so < 0) ? 8'hFF : 8'h00;
      pv <= ((so >= 0) ? (20'h0_0001 << so) : 20'h0_0000) |
            ((se >= 0) ? (20'h0_0001 << se) : 20'h0_0000);
      wr(a, v, PDES_RESP_OKAY);
      repeat (2) @(posedge mclk);
      po = e ? {e_out[ln], e_oe[ln]} : {d_out[ln], d_oe[ln]};
      chk("pad", po, (so == -2) ? 2'b00 : 2'b11);
      chk("analog", analog_enable, an);
      chk("inputs", inx, ix);
      wr(a, 8'h00, PDES_RESP_OKAY);
    end
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    summarize();
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    gpo = 8'h00;
    gpd = 8'h00;
    pin = 8'hFF;
    pv = 20'h0_0000;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Reset values
    for (int i = 0; i < 4; i++)
      rd(8'(4 * i), PDES_SEL_RST, PDES_RESP_OKAY);
    chk("inputs", inx, 9'h11F);
    pin <= 8'h00;
    repeat (2) @(posedge mclk);
    chk("inputs", inx, 9'h100);
    // Lines without a select field follow GPIO
    gpo <= 8'hF0;
    gpd <= 8'h30;
    repeat (2) @(posedge mclk);
    chk("through", {d_out[7:4], d_oe[7:4], e_out[6:3], e_oe[6:3]}, 16'hF3E6);
    pin <= 8'hFF;
    // Storage, unimplemented bits, strobe, unmapped address
    wr(PDES_PDL_OFF, 8'hA5, PDES_RESP_OKAY);
    rd(PDES_PDL_OFF, 8'hA5, PDES_RESP_OKAY);
    wr(PDES_PDH_OFF, 8'hFF, PDES_RESP_OKAY);
    rd(PDES_PDH_OFF, 8'h3F, PDES_RESP_OKAY);
    wr(PDES_PEL_OFF, 8'h5A, PDES_RESP_OKAY);
    rd(PDES_PEL_OFF, 8'h5A, PDES_RESP_OKAY);
    wr(PDES_PEH_OFF, 8'hC3, PDES_RESP_OKAY);
    rd(PDES_PEH_OFF, 8'hC3, PDES_RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(PDES_PEL_OFF, 8'h00, PDES_RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    rd(PDES_PEL_OFF, 8'h5A, PDES_RESP_OKAY);
    wr(8'h10, 8'hFF, PDES_RESP_SLVERR);
    rd(8'h10, 8'h00, PDES_RESP_SLVERR);
    for (int i = 0; i < 4; i++)
      wr(8'(4 * i), 8'h00, PDES_RESP_OKAY);
    // Every field code of every line, except code 10 of port E line 7
    mux(0, 0, 0, -1, -1, 4'h0, 9'h11F);
    mux(0, 0, 1, 2, -1, 4'h0, 9'h10F);
    mux(0, 0, 2, -2, -1, 4'h1, 9'h10F);
    mux(0, 0, 3, 15, -1, 4'h0, 9'h10F);
    mux(0, 1, 0, -1, -1, 4'h0, 9'h11F);
    mux(0, 1, 1, 5, 6, 4'h0, 9'h13B);
    mux(0, 1, 2, -2, -1, 4'h2, 9'h11B);
    mux(0, 1, 3, 14, -1, 4'h0, 9'h11B);
    mux(0, 2, 0, -1, -1, 4'h0, 9'h11F);
    mux(0, 2, 1, 1, -1, 4'h0, 9'h11F);
    mux(0, 2, 2, 4, -1, 4'h0, 9'h11F);
    mux(0, 2, 3, -2, -1, 4'h4, 9'h11F);
    mux(0, 3, 0, -1, -1, 4'h0, 9'h11F);
    mux(0, 3, 1, 0, -1, 4'h0, 9'h11E);
    mux(0, 3, 2, -2, -1, 4'h8, 9'h11E);
    mux(0, 3, 3, 13, -1, 4'h0, 9'h11E);
    mux(1, 0, 0, -1, -1, 4'h0, 9'h11F);
    mux(1, 0, 1, 8, 9, 4'h0, 9'h157);
    mux(1, 0, 2, 11, 12, 4'h0, 9'h117);
    mux(1, 0, 3, 18, -1, 4'h0, 9'h117);
    mux(1, 1, 0, -1, -1, 4'h0, 9'h11F);
    mux(1, 1, 1, 3, -1, 4'h0, 9'h11F);
    mux(1, 1, 2, 10, -1, 4'h0, 9'h11F);
    mux(1, 1, 3, 17, -1, 4'h0, 9'h11F);
    mux(1, 2, 0, -1, -1, 4'h0, 9'h11F);
    mux(1, 2, 1, 7, -1, 4'h0, 9'h11D);
    mux(1, 2, 2, -2, -1, 4'h0, 9'h19D);
    mux(1, 2, 3, 16, -1, 4'h0, 9'h11D);
    // Reserved code of line 7 is never written
    mux(1, 7, 0, -1, -1, 4'h0, 9'h11F);
    mux(1, 7, 1, -1, -1, 4'h0, 9'h11F);
    mux(1, 7, 3, 19, -1, 4'h0, 9'h11F);
    // Chip select input follows a low pin
    wr(PDES_PEL_OFF, 8'h02, PDES_RESP_OKAY);
    pin <= 8'hFE;
    repeat (2) @(posedge mclk);
    chk("inputs", inx, 9'h007);
    summarize();
  end
endmodule
`default_nettype wire
